/* File: tsp_port.sv */
`timescale 1ns/1ps
module tsp_port
  import tsp_pkg::*;
#(
  parameter bit VARIANT27 = 1'b1,
  parameter int TIMEOUT_LEN = TIMEOUT_CYCLES
)
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic linkClk,
  // two-wire pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic hsFilterEn,
  // address-select pins
  input wire logic [2:0] addrSelectPinLevel,
  input wire logic [2:0] addrSelectPinFloat,
  // sensor core
  input wire logic [11:0] temperature,
  input wire logic alertActive,
  input wire logic alertHigh,
  output logic [7:0] configValue,
  output logic [15:0] lowerLimitValue,
  output logic [15:0] upperLimitValue,
  output logic alertClear,
  output logic regsReset
);
  localparam int TO_W = $clog2(TIMEOUT_LEN + 1);

  logic linkRstMeta;
  logic linkRst_n;
  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic sclS;
  logic sdaS;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  tsp_state_t state;
  tsp_rx_t rxKind;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic [7:0] txShift;
  logic txAlert;
  logic goTx;
  logic goWait;
  logic masterAck;
  logic byteIdx;
  logic [1:0] ptr;
  logic [7:0] cfgShadow;
  logic [15:0] lowShadow;
  logic [15:0] highShadow;
  logic [7:0] hiHold;
  logic [6:0] ownAddr;
  logic [6:0] decodedAddr;
  logic addrFresh;
  logic [TO_W-1:0] toCnt;
  logic toHit;
  logic byteDone;
  logic hitOwn;
  logic hitAra;
  logic hitGc;
  logic hitHs;
  logic ackNow;
  logic writeCommit;
  logic [15:0] readWord;
  logic [7:0] txByte;
  logic thermostatBehaviourBit;
  logic [STAT_W-1:0] linkStat;
  logic cmdValid;
  logic [CMD_W-1:0] cmdData;
  logic coreCmdValid;
  logic [CMD_W-1:0] coreCmd;

  // reset release reaches the link domain through two flops
  always_ff @(posedge linkClk)
  begin
    linkRstMeta <= rst_n;
    linkRst_n <= linkRstMeta;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pinSync
      logic pinRaw;
      if (gi < 3)
      begin : g_lvl
        assign pinRaw = addrSelectPinLevel[gi];
      end
      else if (gi < 6)
      begin : g_flt
        assign pinRaw = addrSelectPinFloat[gi-3];
      end
      else if (gi == 6)
      begin : g_scl
        assign pinRaw = sclIn;
      end
      else
      begin : g_sda
        assign pinRaw = sdaIn;
      end
      always_ff @(posedge linkClk)
      begin
        pinMeta[gi] <= pinRaw;
        pinSync[gi] <= pinMeta[gi];
      end
    end
  endgenerate

  assign sclS = pinSync[6];
  assign sdaS = pinSync[7];

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startDet = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopDet = sclS && sclPrev && !sdaPrev && sdaS;
  assign thermostatBehaviourBit = cfgShadow[CFG_TM_BIT];

  tsp_addr_decode #(.VARIANT27(VARIANT27)) u_decode (
    .pinLevel(pinSync[2:0]),
    .pinFloat(VARIANT27 ? pinSync[5:3] : 3'h0),
    .targetAddr(decodedAddr)
  );

  always_comb
  begin
    byteDone = state == S_RX && sclFall && bitCnt == BYTE_BITS;
    hitOwn = rxKind == RX_ADDR && shift[7:1] == ownAddr;
    hitAra = rxKind == RX_ADDR && shift == ALERT_RESP_BYTE && thermostatBehaviourBit
      && linkStat[13];
    hitGc = rxKind == RX_ADDR && shift == GC_ADDR_BYTE;
    hitHs = rxKind == RX_ADDR && shift[7:3] == HS_CODE_HI;
    ackNow = rxKind != RX_ADDR || hitOwn || hitAra || hitGc;
    writeCommit = (ptr == PTR_CONFIG && !byteIdx) || (ptr[1] && byteIdx);
    case (ptr)
      PTR_TEMP: readWord = {linkStat[11:0], 4'h0};
      PTR_CONFIG: readWord = {cfgShadow & CFG_READ_MASK, 8'h00};
      PTR_LOW: readWord = lowShadow;
      default: readWord = highShadow;
    endcase
    // alert answer carries own address and which limit was crossed
    txByte = txAlert ? {ownAddr, linkStat[12]}
      : (byteIdx ? readWord[7:0] : readWord[15:8]);
  end

  always_ff @(posedge linkClk)
  begin
    sdaOut <= 1'b0;
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n || toHit)
    begin
      state <= S_IDLE;
      sdaOe <= 1'b0;
      rxKind <= RX_ADDR;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      txShift <= 8'h00;
      txAlert <= 1'b0;
      goTx <= 1'b0;
      goWait <= 1'b0;
      masterAck <= 1'b0;
      byteIdx <= 1'b0;
    end
    else if (startDet || stopDet)
    begin
      // repeated START or STOP ends any transfer and drops the data drive
      state <= startDet ? S_RX : S_IDLE;
      sdaOe <= 1'b0;
      rxKind <= RX_ADDR;
      bitCnt <= 4'h0;
      byteIdx <= 1'b0;
    end
    else
    begin
      case (state)
        S_RX:
        begin
          if (sclRise)
          begin
            shift <= {shift[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
          end
          else if (byteDone)
          begin
            state <= ackNow ? S_ACK : S_WAIT;
            sdaOe <= ackNow;
            goTx <= 1'b0;
            goWait <= 1'b0;
            case (rxKind)
              RX_ADDR:
              begin
                txAlert <= hitAra;
                goTx <= hitAra || (hitOwn && shift[0]);
                rxKind <= hitGc ? RX_GC : RX_PTR;
                byteIdx <= 1'b0;
              end
              RX_PTR:
              begin
                rxKind <= RX_DATA;
                byteIdx <= 1'b0;
              end
              RX_DATA: byteIdx <= !byteIdx;
              default: goWait <= 1'b1;
            endcase
          end
        end
        S_ACK:
        begin
          if (sclFall)
          begin
            bitCnt <= 4'h0;
            txShift <= txByte;
            sdaOe <= goTx && !txByte[7];
            state <= goTx ? S_TX : (goWait ? S_WAIT : S_RX);
          end
        end
        S_TX:
        begin
          if (sclRise && txAlert && !sdaOe && !sdaS)
          begin
            state <= S_WAIT;
          end
          else if (sclFall)
          begin
            if (bitCnt == LAST_BIT)
            begin
              sdaOe <= 1'b0;
              state <= S_TXACK;
            end
            else
            begin
              txShift <= {txShift[6:0], 1'b0};
              sdaOe <= !txShift[6];
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        S_TXACK:
        begin
          if (sclRise)
          begin
            masterAck <= !sdaS;
            if (!sdaS)
            begin
              byteIdx <= !byteIdx;
            end
          end
          else if (sclFall)
          begin
            bitCnt <= 4'h0;
            txShift <= txByte;
            sdaOe <= masterAck && !txAlert && !txByte[7];
            state <= (masterAck && !txAlert) ? S_TX : S_WAIT;
          end
        end
        S_IDLE, S_WAIT: state <= state;
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n)
    begin
      ptr <= PTR_RESET;
      cfgShadow <= CFG_RESET;
      lowShadow <= LIMIT_RESET;
      highShadow <= LIMIT_RESET;
      hiHold <= 8'h00;
    end
    else if (byteDone && rxKind == RX_PTR)
    begin
      ptr <= shift[1:0];
    end
    else if (byteDone && rxKind == RX_GC && shift == GC_RESET)
    begin
      ptr <= PTR_RESET;
      cfgShadow <= CFG_RESET;
      lowShadow <= LIMIT_RESET;
      highShadow <= LIMIT_RESET;
    end
    else if (byteDone && rxKind == RX_DATA)
    begin
      hiHold <= shift;
      if (ptr == PTR_CONFIG && !byteIdx)
      begin
        cfgShadow <= shift;
      end
      else if (ptr == PTR_LOW && byteIdx)
      begin
        lowShadow <= {hiHold, shift};
      end
      else if (ptr == PTR_HIGH && byteIdx)
      begin
        highShadow <= {hiHold, shift};
      end
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n)
    begin
      ownAddr <= ADDR_BIN_BASE;
      addrFresh <= 1'b0;
    end
    else if (!addrFresh || startDet
      || (byteDone && rxKind == RX_GC && (shift == GC_RELATCH || shift == GC_RESET)))
    begin
      ownAddr <= decodedAddr;
      addrFresh <= 1'b1;
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n || stopDet)
    begin
      hsFilterEn <= 1'b0;
    end
    else if (byteDone && hitHs)
    begin
      hsFilterEn <= 1'b1;
    end
  end

  // clock stuck low or data stuck low both count; only inside a frame
  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n || state == S_IDLE || (sclS && sdaS) || startDet || toHit)
    begin
      toCnt <= '0;
    end
    else
    begin
      toCnt <= toCnt + 1'b1;
    end
  end

  assign toHit = VARIANT27 && toCnt == TO_W'(TIMEOUT_LEN - 1);

  // commands to the core are a byte time apart, far longer than the handshake
  always_ff @(posedge linkClk)
  begin
    if (!linkRst_n)
    begin
      cmdValid <= 1'b0;
      cmdData <= '0;
    end
    else
    begin
      cmdValid <= 1'b0;
      if (byteDone && rxKind == RX_DATA && writeCommit)
      begin
        cmdValid <= 1'b1;
        cmdData <= {CMD_WRITE, ptr, ptr == PTR_CONFIG ? {shift, 8'h00} : {hiHold, shift}};
      end
      else if (byteDone && rxKind == RX_GC && shift == GC_RESET)
      begin
        cmdValid <= 1'b1;
        cmdData <= {CMD_GC_RESET, PTR_RESET, LIMIT_RESET};
      end
      else if (state == S_TXACK && sclRise
        && (txAlert || (ptr == PTR_TEMP && !byteIdx && thermostatBehaviourBit)))
      begin
        cmdValid <= 1'b1;
        cmdData <= {CMD_ALERT_CLR, PTR_TEMP, LIMIT_RESET};
      end
    end
  end

  tsp_word_cdc #(.W(CMD_W)) u_cmdCdc (
    .srcClk(linkClk), .srcRst_n(linkRst_n), .srcValid(cmdValid), .srcData(cmdData),
    .srcBusy(), .dstClk(core_clk), .dstRst_n(rst_n), .dstValid(coreCmdValid),
    .dstData(coreCmd)
  );

  tsp_word_cdc #(.W(STAT_W)) u_statCdc (
    .srcClk(core_clk), .srcRst_n(rst_n), .srcValid(1'b1),
    .srcData({alertActive, alertHigh, temperature}), .srcBusy(), .dstClk(linkClk),
    .dstRst_n(linkRst_n), .dstValid(), .dstData(linkStat)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      configValue <= CFG_RESET;
      lowerLimitValue <= LIMIT_RESET;
      upperLimitValue <= LIMIT_RESET;
      alertClear <= 1'b0;
      regsReset <= 1'b0;
    end
    else
    begin
      alertClear <= coreCmdValid && coreCmd[CMD_OP_LSB+:2] == CMD_ALERT_CLR;
      regsReset <= coreCmdValid && coreCmd[CMD_OP_LSB+:2] == CMD_GC_RESET;
      if (coreCmdValid && coreCmd[CMD_OP_LSB+:2] == CMD_GC_RESET)
      begin
        configValue <= CFG_RESET;
        lowerLimitValue <= LIMIT_RESET;
        upperLimitValue <= LIMIT_RESET;
      end
      else if (coreCmdValid && coreCmd[CMD_OP_LSB+:2] == CMD_WRITE)
      begin
        case (coreCmd[CMD_PTR_LSB+:2])
          PTR_CONFIG: configValue <= coreCmd[15:8];
          PTR_LOW: lowerLimitValue <= coreCmd[15:0];
          PTR_HIGH: upperLimitValue <= coreCmd[15:0];
          default: configValue <= configValue;
        endcase
      end
    end
  end

  property p_ackOwn;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && hitOwn && !toHit |=> sdaOe && state == S_ACK;
  endproperty
  a_ackOwn: assert property (p_ackOwn) else $error("own address not acknowledged");
  property p_nackOther;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && !ackNow && !toHit |=> !sdaOe && state == S_WAIT;
  endproperty
  a_nackOther: assert property (p_nackOther) else $error("foreign byte acknowledged");
  property p_ptrLoad;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && rxKind == RX_PTR |=> ptr == $past(shift[1:0]);
  endproperty
  a_ptrLoad: assert property (p_ptrLoad) else $error("pointer byte not loaded");
  property p_ptrHold;
    @(posedge linkClk) disable iff (!linkRst_n)
      !(byteDone && (rxKind == RX_PTR || rxKind == RX_GC)) |=> $stable(ptr);
  endproperty
  a_ptrHold: assert property (p_ptrHold) else $error("pointer changed without write");
  property p_hsEnter;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && hitHs && !toHit && !stopDet |=> hsFilterEn && !sdaOe;
  endproperty
  a_hsEnter: assert property (p_hsEnter) else $error("master code mishandled");
  property p_hsExit;
    @(posedge linkClk) disable iff (!linkRst_n)
      stopDet |=> !hsFilterEn;
  endproperty
  a_hsExit: assert property (p_hsExit) else $error("high speed kept after stop");
  property p_quiet;
    @(posedge linkClk) disable iff (!linkRst_n)
      state == S_WAIT || state == S_IDLE |-> !sdaOe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data driven outside transfer");
  property p_gcReset;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && rxKind == RX_GC && shift == GC_RESET |=> cfgShadow == CFG_RESET
        && ptr == PTR_RESET && cmdValid && cmdData[CMD_OP_LSB+:2] == CMD_GC_RESET;
  endproperty
  a_gcReset: assert property (p_gcReset) else $error("general reset not applied");
  property p_timeout;
    @(posedge linkClk) disable iff (!linkRst_n)
      toHit |=> state == S_IDLE && !sdaOe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out did not release");
  property p_araAck;
    @(posedge linkClk) disable iff (!linkRst_n)
      byteDone && hitAra && !toHit |=> sdaOe && txAlert;
  endproperty
  a_araAck: assert property (p_araAck) else $error("alert response not answered");
  property p_alertClr;
    @(posedge core_clk) disable iff (!rst_n)
      coreCmdValid && coreCmd[CMD_OP_LSB+:2] == CMD_ALERT_CLR |=> alertClear ##1 !alertClear;
  endproperty
  a_alertClr: assert property (p_alertClr) else $error("alert clear not pulsed");
endmodule // tsp_port

/* File: tsp_pkg.sv */
// Notes on behaviour
// - First byte after START: seven address bits, then direction bit, low means write.
// - Wide variant, pins all driven: address 1001 followed by pins 2, 1, 0.
// - Wide variant: floating pin is third level; float combinations map to fixed addresses.
// - Narrow variant: three binary pins form low bits of 1001xxx addresses.
// - Address pins read after reset, at each START, on re-latch command; then held.
// - First byte after a write-direction address loads the register-select pointer.
// - Reads use the last written pointer; pointer kept until another write.
// - Register words go high byte first, each byte most significant bit first.
// - Acknowledge matching address, pointer and data bytes; data lands in selected register.
// - Read-direction match: acknowledge, send high byte then low byte of selected register.
// - Controller may end a read by not-acknowledge, START or STOP; data drive stops.
// - Interrupt mode, alert active, alert-response address arrives: acknowledge, return own address.
// - Alert response eighth bit: one at or above upper limit, zero below lower.
// - Alert response arbitrates; winner clears its alert at completion, loser keeps it.
// - Acknowledge general-call address with write direction; next byte is a command.
// - Command 04 re-latches address pins; command 06 re-latches and resets registers.
// - High-speed master code as first byte: not acknowledged, filters go high-speed.
// - High-speed operation lasts until STOP, then filters return to fast mode.
// - Two low pointer bits select temperature, configuration, lower or upper limit; reset 00.
// - Interrupt mode: reading the temperature register clears an active alert.
package tsp_pkg;
  localparam logic [6:0] ADDR_BIN_BASE = 7'h48;
  localparam logic [6:0] ADDR_F2_BASE = 7'h70;
  localparam logic [6:0] ADDR_F1_BASE = 7'h28;
  localparam logic [6:0] ADDR_F0_BASE = 7'h2c;
  localparam logic [6:0] ADDR_F10_LO = 7'h35;
  localparam logic [6:0] ADDR_F10_HI = 7'h36;
  localparam logic [6:0] ADDR_FALL = 7'h37;
  localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RELATCH = 8'h04;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [4:0] HS_CODE_HI = 5'h01;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOW = 2'h2;
  localparam logic [1:0] PTR_HIGH = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam int CFG_TM_BIT = 1;
  localparam logic [7:0] CFG_READ_MASK = 8'h7f;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int TIMEOUT_MS = 54;
  localparam int LINK_CLK_HZ = 66666667;
  localparam int TIMEOUT_CYCLES = LINK_CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int CMD_W = 20;
  localparam int CMD_OP_LSB = 18;
  localparam int CMD_PTR_LSB = 16;
  localparam int STAT_W = 14;
  typedef enum logic [1:0] {CMD_NONE = 2'h0, CMD_WRITE = 2'h1, CMD_GC_RESET = 2'h2,
    CMD_ALERT_CLR = 2'h3} tsp_cmd_t;
  typedef enum logic [1:0] {RX_ADDR = 2'h0, RX_PTR = 2'h1, RX_DATA = 2'h2,
    RX_GC = 2'h3} tsp_rx_t;
  typedef enum logic [2:0] {S_IDLE = 3'h0, S_RX = 3'h1, S_ACK = 3'h2, S_TX = 3'h3,
    S_TXACK = 3'h4, S_WAIT = 3'h5} tsp_state_t;
endpackage

/* File: tsp_addr_decode.sv */
`timescale 1ns/1ps
module tsp_addr_decode
  import tsp_pkg::*;
#(
  parameter bit VARIANT27 = 1'b1
)
(
  // sampled address-select pins
  input wire logic [2:0] pinLevel,
  input wire logic [2:0] pinFloat,
  // decoded target address
  output logic [6:0] targetAddr
);
  logic [2:0] f2Off;

  always_comb
  begin
    f2Off = 3'h0;
    case ({pinLevel[1], pinLevel[0]})
      2'b00: f2Off = 3'h0;
      2'b01: f2Off = 3'h2;
      2'b10: f2Off = 3'h3;
      default: f2Off = 3'h5;
    endcase
    targetAddr = ADDR_BIN_BASE | {4'h0, pinLevel};
    if (VARIANT27)
    begin
      case (pinFloat)
        3'b100: targetAddr = ADDR_F2_BASE | {4'h0, f2Off};
        3'b101: targetAddr = ADDR_F2_BASE | (pinLevel[1] ? 7'h04 : 7'h01);
        3'b110: targetAddr = ADDR_F2_BASE | (pinLevel[0] ? 7'h07 : 7'h06);
        3'b111: targetAddr = ADDR_FALL;
        3'b010: targetAddr = ADDR_F1_BASE | {5'h00, pinLevel[2], pinLevel[0]};
        3'b001: targetAddr = ADDR_F0_BASE | {5'h00, pinLevel[2], pinLevel[1]};
        3'b011: targetAddr = pinLevel[2] ? ADDR_F10_HI : ADDR_F10_LO;
        default: targetAddr = ADDR_BIN_BASE | {4'h0, pinLevel};
      endcase
    end
  end
endmodule // tsp_addr_decode

/* File: tsp_word_cdc.sv */
`timescale 1ns/1ps
module tsp_word_cdc #(
  parameter int W = 8
)
(
  // source side
  input wire logic srcClk,
  input wire logic srcRst_n,
  input wire logic srcValid,
  input wire logic [W-1:0] srcData,
  output logic srcBusy,
  // destination side
  input wire logic dstClk,
  input wire logic dstRst_n,
  output logic dstValid,
  output logic [W-1:0] dstData
);
  logic reqTgl;
  logic ackMeta;
  logic ackSync;
  logic reqMeta;
  logic reqSync;
  logic reqSeen;
  logic [W-1:0] hold;

  // hold stays still from toggle until ack returns, so dst may sample it
  assign srcBusy = reqTgl != ackSync;

  always_ff @(posedge srcClk)
  begin
    if (!srcRst_n)
    begin
      reqTgl <= 1'b0;
      hold <= '0;
    end
    else if (srcValid && !srcBusy)
    begin
      hold <= srcData;
      reqTgl <= !reqTgl;
    end
  end

  always_ff @(posedge srcClk)
  begin
    if (!srcRst_n)
    begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end
    else
    begin
      ackMeta <= reqSeen;
      ackSync <= ackMeta;
    end
  end

  always_ff @(posedge dstClk)
  begin
    if (!dstRst_n)
    begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
      reqSeen <= 1'b0;
      dstValid <= 1'b0;
      dstData <= '0;
    end
    else
    begin
      reqMeta <= reqTgl;
      reqSync <= reqMeta;
      dstValid <= reqSync != reqSeen;
      if (reqSync != reqSeen)
      begin
        reqSeen <= reqSync;
        dstData <= hold;
      end
    end
  end
endmodule // tsp_word_cdc

/* File: tsp_ctrl_model.sv */
`timescale 1ns/1ps
module tsp_ctrl_model
(
  // two-wire lines
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  // quarter bit time; 240 ns scl period, far above the 1 kHz floor
  localparam int Q = 60;
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // open drain: a one releases the line, the pull-up does the rest
  task automatic bitx(input logic b, output logic r);
    #Q sdaLow = !b;
    #Q scl = 1'b1;
    #Q r = sdaWire;
    #Q scl = 1'b0;
  endtask
  task automatic start();
    #Q sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // address, pointer, data or code byte; msb first
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // last byte gets a not-acknowledge
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule // tsp_ctrl_model

/* File: temp_sensor_i2c_target_port_bench.sv */
`timescale 1ns/1ps
module temp_sensor_i2c_target_port_bench;
  import tsp_pkg::*;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, hsFilterEn, alertClear, regsReset, ack;
  logic [2:0] pinLevel = 3'h0;
  logic [2:0] pinFloat = 3'h0;
  logic [11:0] temperature = 12'h000;
  logic alertActive = 1'b0;
  logic alertHigh = 1'b0;
  logic [7:0] configValue, b;
  logic [15:0] lowerLimitValue, upperLimitValue, v;
  int nClear = 0;
  int nReset = 0;
  int err_count = 0;
  int n_tests = 0;
  wire sda = !(sdaOe || sdaLow);
  initial
    forever #2 core_clk = !core_clk;
  initial
  begin
    #3;
    forever #7.5 linkClk = !linkClk;
  end
  // short time-out, yet well above the longest low stretch of any frame sent here except the t_timeout stall
  tsp_port #(.VARIANT27(1'b1), .TIMEOUT_LEN(1000)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .linkClk(linkClk), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .hsFilterEn(hsFilterEn), .addrSelectPinLevel(pinLevel), .addrSelectPinFloat(pinFloat),
    .temperature(temperature), .alertActive(alertActive), .alertHigh(alertHigh),
    .configValue(configValue), .lowerLimitValue(lowerLimitValue),
    .upperLimitValue(upperLimitValue), .alertClear(alertClear), .regsReset(regsReset));
  tsp_ctrl_model m (.sdaWire(sda), .scl(scl), .sdaLow(sdaLow));
  // pulses are one core cycle wide, so catch them here
  always @(posedge core_clk)
  begin
    if (alertClear === 1'b1)
      nClear <= nClear + 1;
    if (regsReset === 1'b1)
      nReset <= nReset + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (30) @(posedge core_clk);
    #1;
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [15:0] d, input int n);
    m.start();
    m.wr({ADDR_BIN_BASE, 1'b0}, ack);
    check(ack, 1'b1);
    m.wr(p, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.wr(d[15-8*i -: 8], ack);
      check(ack, 1'b1);
    end
    m.stop();
    settle();
  endtask
  task automatic rdReg(input logic setPtr, input logic [7:0] p, output logic [15:0] r);
    m.start();
    if (setPtr)
    begin
      m.wr({ADDR_BIN_BASE, 1'b0}, ack);
      m.wr(p, ack);
      m.start();
    end
    m.wr({ADDR_BIN_BASE, 1'b1}, ack);
    check(ack, 1'b1);
    m.rd(1'b0, r[15:8]);
    m.rd(1'b1, r[7:0]);
    m.stop();
  endtask
  task automatic t_regs();
    wrReg({6'h00, PTR_CONFIG}, 16'h0200, 1);
    check(configValue, 8'h02);
    wrReg({6'h00, PTR_HIGH}, 16'h1234, 2);
    check(upperLimitValue, 16'h1234);
    wrReg({6'h00, PTR_LOW}, 16'h8ce0, 2);
    check(lowerLimitValue, 16'h8ce0);
    rdReg(1'b1, {6'h00, PTR_CONFIG}, v);
    check(v, 16'h0200);
    rdReg(1'b1, {6'h00, PTR_HIGH}, v);
    check(v, 16'h1234);
    rdReg(1'b0, 8'h00, v);
    check(v, 16'h1234);
    @(posedge core_clk) #1 temperature = 12'h4b0;
    settle();
    rdReg(1'b1, {6'h00, PTR_TEMP}, v);
    check(v, 16'h4b00);
    check(16'(nClear), 16'h0001);
    $display("test regs done");
  endtask
  task automatic t_alert();
    @(posedge core_clk) #1 alertActive = 1'b1;
    alertHigh = 1'b1;
    settle();
    m.start();
    m.wr(ALERT_RESP_BYTE, ack);
    check(ack, 1'b1);
    m.rd(1'b1, b);
    check(b, {ADDR_BIN_BASE, 1'b1});
    m.stop();
    settle();
    check(16'(nClear), 16'h0002);
    $display("test alert done");
  endtask
  task automatic t_hs();
    m.start();
    m.wr(8'h0b, ack);
    check(ack, 1'b0);
    check(hsFilterEn, 1'b1);
    m.stop();
    settle();
    check(hsFilterEn, 1'b0);
    $display("test hs done");
  endtask
  task automatic t_addr();
    @(posedge core_clk) #1 pinFloat = 3'h7;
    settle();
    m.start();
    m.wr({ADDR_FALL, 1'b0}, ack);
    check(ack, 1'b1);
    m.stop();
    m.start();
    m.wr({ADDR_BIN_BASE, 1'b0}, ack);
    check(ack, 1'b0);
    m.stop();
    @(posedge core_clk) #1 pinFloat = 3'h0;
    $display("test addr done");
  endtask
  task automatic t_gc();
    m.start();
    m.wr(GC_ADDR_BYTE, ack);
    check(ack, 1'b1);
    m.wr(GC_RESET, ack);
    check(ack, 1'b1);
    m.stop();
    settle();
    check(16'(nReset), 16'h0001);
    check(configValue, CFG_RESET);
    check(upperLimitValue, LIMIT_RESET);
    $display("test gc done");
  endtask
  // stall scl low while the device drives a zero; it must let go by itself
  task automatic t_timeout();
    m.start();
    m.wr({ADDR_BIN_BASE, 1'b1}, ack);
    check(ack, 1'b1);
    settle();
    check(sdaOe, 1'b1);
    check(sdaOut, 1'b0);
    repeat (5000) @(posedge core_clk);
    #1;
    check(sdaOe, 1'b0);
    m.stop();
    $display("test timeout done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (40) @(posedge core_clk);
    t_regs();
    t_alert();
    t_hs();
    t_addr();
    t_gc();
    t_timeout();
    final_report();
  end
endmodule // temp_sensor_i2c_target_port_bench
